// ===== hdl/rcrf_pkg.sv
// Package holding the frame layout constants of the remote command request framer.
package rcrf_pkg;
  localparam logic [7:0] RCRF_DELIM = 8'h7e;
  localparam logic [7:0] RCRF_TYPE_REMOTE_CMD = 8'h17;
  localparam logic [7:0] RCRF_CSUM_BASE = 8'hff;
  localparam logic [15:0] RCRF_NET_UNKNOWN = 16'hfffe;
  localparam logic [7:0] RCRF_OPT_NO_ACK = 8'h01;
  localparam logic [7:0] RCRF_OPT_APPLY = 8'h02;
  localparam logic [7:0] RCRF_OPT_EXT_TMO = 8'h40;
  // Byte positions within a frame.
  localparam logic [7:0] RCRF_POS_TYPE = 8'h03;
  localparam logic [7:0] RCRF_POS_ID = 8'h04;
  localparam logic [7:0] RCRF_POS_ADDR64 = 8'h05;
  localparam logic [7:0] RCRF_POS_ADDR64_END = 8'h0c;
  localparam logic [7:0] RCRF_POS_NET_HI = 8'h0d;
  localparam logic [7:0] RCRF_POS_NET_LO = 8'h0e;
  localparam logic [7:0] RCRF_POS_OPT = 8'h0f;
  localparam logic [7:0] RCRF_POS_CMD_HI = 8'h10;
  localparam logic [7:0] RCRF_POS_CMD_LO = 8'h11;
  localparam logic [7:0] RCRF_POS_PARAM = 8'h12;
  // Bytes from type code through command name; parameter bytes add to this.
  localparam logic [15:0] RCRF_HDR_LEN = 16'h000f;
  localparam int RCRF_PARAM_MAX = 16;
  localparam logic [4:0] RCRF_PARAM_MAX_W = 5'h10;
endpackage

// ===== hdl/rcrf_link_if.sv
// Interface carrying the serial frame byte stream from host to module.
`timescale 1ns/100ps
interface rcrf_link_if;
  logic [7:0] data;
  logic valid;
  logic ready;
  modport host (output data, output valid, input ready);
  modport module_end (input data, input valid, output ready);
endinterface

// ===== hdl/rcrf_host.sv
// Host end: builds remote command request frames onto the byte link.
`timescale 1ns/100ps
module rcrf_host
(
  input wire logic mclk_in, // clock
  input wire logic rst_in, // synchronous reset, active high
  input wire logic ce_in, // clock enable
  rcrf_link_if.host link, // byte link to the module
  input wire logic req_in, // pulse: start a frame
  input wire logic [7:0] id_in, // correlation identifier, zero for no reply
  input wire logic [63:0] addr64_in, // destination long address
  input wire logic [15:0] net_in, // destination network address
  input wire logic net_known_in, // network address is known
  input wire logic [7:0] opt_in, // option bits
  input wire logic [15:0] cmd_in, // two-character command name
  input wire logic [4:0] plen_in, // parameter byte count
  input wire logic [8*rcrf_pkg::RCRF_PARAM_MAX-1:0] param_in, // parameter bytes, byte 0 first
  output logic busy_out // frame in progress
);
  import rcrf_pkg::*;

  logic [7:0] pos_q;
  logic [7:0] last_q;
  logic [7:0] sum_q;
  logic [7:0] id_q, opt_q;
  logic [63:0] a64_q;
  logic [15:0] net_q, cmd_q, len_q;
  logic [8*RCRF_PARAM_MAX-1:0] par_q;
  logic [7:0] byte_d;
  logic valid_q;
  logic [7:0] data_q;
  logic [2:0] a_idx;
  logic [3:0] p_idx;

  assign link.valid = valid_q;
  assign link.data = data_q;
  assign a_idx = 3'(pos_q - RCRF_POS_ADDR64);
  assign p_idx = 4'(pos_q - RCRF_POS_PARAM);

  always_comb
  begin
    byte_d = 8'h00;
    if (pos_q == 8'h00) byte_d = RCRF_DELIM;
    else if (pos_q == 8'h01) byte_d = len_q[15:8];
    else if (pos_q == 8'h02) byte_d = len_q[7:0];
    else if (pos_q == RCRF_POS_TYPE) byte_d = RCRF_TYPE_REMOTE_CMD;
    else if (pos_q == RCRF_POS_ID) byte_d = id_q;
    else if (pos_q <= RCRF_POS_ADDR64_END) byte_d = a64_q[8*(7-a_idx) +: 8];
    else if (pos_q == RCRF_POS_NET_HI) byte_d = net_q[15:8];
    else if (pos_q == RCRF_POS_NET_LO) byte_d = net_q[7:0];
    else if (pos_q == RCRF_POS_OPT) byte_d = opt_q;
    else if (pos_q == RCRF_POS_CMD_HI) byte_d = cmd_q[15:8];
    else if (pos_q == RCRF_POS_CMD_LO) byte_d = cmd_q[7:0];
    else if (pos_q < last_q) byte_d = par_q[8*p_idx +: 8];
    else byte_d = RCRF_CSUM_BASE - sum_q;
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      busy_out <= 1'b0;
      valid_q <= 1'b0;
      data_q <= 8'h00;
      pos_q <= 8'h00;
      last_q <= 8'h00;
      sum_q <= 8'h00;
      id_q <= 8'h00;
      opt_q <= 8'h00;
      a64_q <= 64'h0;
      net_q <= 16'h0;
      cmd_q <= 16'h0;
      len_q <= 16'h0;
      par_q <= '0;
    end
    else if (ce_in)
    begin
      if (!busy_out && req_in)
      begin
        busy_out <= 1'b1;
        pos_q <= 8'h00;
        sum_q <= 8'h00;
        id_q <= id_in;
        opt_q <= opt_in;
        a64_q <= addr64_in;
        net_q <= net_known_in ? net_in : RCRF_NET_UNKNOWN;
        cmd_q <= cmd_in;
        par_q <= param_in;
        // Oversized parameter counts are clipped to the buffer.
        len_q <= RCRF_HDR_LEN + 16'((plen_in > RCRF_PARAM_MAX_W) ? RCRF_PARAM_MAX_W : plen_in);
        last_q <= RCRF_POS_PARAM + 8'((plen_in > RCRF_PARAM_MAX_W) ? RCRF_PARAM_MAX_W : plen_in);
        valid_q <= 1'b0;
      end
      else if (busy_out)
      begin
        if (!valid_q)
        begin
          data_q <= byte_d;
          valid_q <= 1'b1;
        end
        else if (link.ready)
        begin
          // Each accepted byte is followed by an idle cycle, so byte_d can follow the new
          // position from a register; the link runs at half rate in exchange.
          valid_q <= 1'b0;
          if (pos_q == last_q)
            busy_out <= 1'b0;
          else
          begin
            pos_q <= pos_q + 8'h01;
            // The sum covers the type code through the last parameter byte.
            if (pos_q >= RCRF_POS_TYPE)
              sum_q <= sum_q + data_q;
          end
        end
      end
    end
  end
endmodule

// ===== hdl/rcrf_module.sv
// Module end: receives and checks remote command request frames from the byte link.
// Summary of operation
// - Host puts type 0x17 at byte three.
// - Byte four is reply identifier; zero suppresses reply.
// - Long address bytes five to twelve, MSB first.
// - All-zero long address means the coordinator.
// - Network address bytes, 0xFFFE when unknown.
// - Option 0x01 sends without remote acknowledgement.
// - Option 0x40 applies extended transmission timeout.
// - Writes take effect on apply bit or command.
// - Command name is two ASCII bytes.
// - Parameter bytes mean write, none means query.
`timescale 1ns/100ps
module rcrf_module
(
  input wire logic mclk_in, // clock
  input wire logic rst_in, // synchronous reset, active high
  input wire logic ce_in, // clock enable
  rcrf_link_if.module_end link, // byte link from the host
  output logic req_valid_out, // pulse: checked request ready
  output logic [7:0] id_out, // correlation identifier
  output logic reply_out, // a reply is to be sent
  output logic [63:0] addr64_out, // destination long address
  output logic coord_out, // destination is the coordinator
  output logic [15:0] net_out, // destination network address
  output logic net_unknown_out, // network address is 0xFFFE, unknown
  output logic no_ack_out, // send without remote acknowledgement
  output logic ext_tmo_out, // use extended transmission timeout
  output logic apply_out, // apply changes after the write
  output logic [15:0] cmd_out, // command name
  output logic write_out, // request writes a parameter
  output logic [4:0] plen_out, // parameter byte count
  output logic [8*rcrf_pkg::RCRF_PARAM_MAX-1:0] param_out, // parameter bytes, byte 0 first
  output logic drop_out // pulse: frame discarded
);
  import rcrf_pkg::*;

  typedef enum {RCRF_IDLE, RCRF_LEN_HI, RCRF_LEN_LO, RCRF_BODY, RCRF_CSUM} rcrf_state_t;
  rcrf_state_t state_q;
  logic [15:0] len_q, cnt_q;
  logic [7:0] sum_q, pos_q, type_q, id_q, opt_q;
  logic [63:0] a64_q;
  logic [15:0] net_q, cmd_q;
  logic [8*RCRF_PARAM_MAX-1:0] par_q;
  logic [4:0] plen_q;
  logic take;
  logic frame_bad;
  logic [2:0] a_idx;

  assign link.ready = ce_in && !rst_in;
  assign take = link.valid && ce_in;
  assign a_idx = 3'(pos_q - RCRF_POS_ADDR64);
  // A frame is refused for a bad checksum, a foreign type or a length too short for the header.
  assign frame_bad = (RCRF_CSUM_BASE - sum_q != link.data)
    || (type_q != RCRF_TYPE_REMOTE_CMD) || (len_q < RCRF_HDR_LEN);

  // Frame state; a delimiter inside a frame does not resync, the length alone ends it.
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      state_q <= RCRF_IDLE;
    else if (take)
    begin
      case (state_q)
        RCRF_IDLE:
          if (link.data == RCRF_DELIM)
            state_q <= RCRF_LEN_HI;
        RCRF_LEN_HI:
          state_q <= RCRF_LEN_LO;
        RCRF_LEN_LO:
          state_q <= ({len_q[15:8], link.data} == 16'h0) ? RCRF_CSUM : RCRF_BODY;
        RCRF_BODY:
          if (cnt_q + 16'h1 == len_q)
            state_q <= RCRF_CSUM;
        RCRF_CSUM:
          state_q <= RCRF_IDLE;
        default:
          state_q <= RCRF_IDLE;
      endcase
    end
  end

  // Length, body count, byte position and running sum.
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      len_q <= 16'h0;
      cnt_q <= 16'h0;
      sum_q <= 8'h00;
      pos_q <= 8'h00;
    end
    else if (take && state_q == RCRF_LEN_HI)
      len_q[15:8] <= link.data;
    else if (take && state_q == RCRF_LEN_LO)
    begin
      len_q[7:0] <= link.data;
      cnt_q <= 16'h0;
      sum_q <= 8'h00;
      pos_q <= RCRF_POS_TYPE;
    end
    else if (take && state_q == RCRF_BODY)
    begin
      sum_q <= sum_q + link.data;
      cnt_q <= cnt_q + 16'h1;
      // Saturating keeps an overlong frame from wrapping back onto the header fields.
      pos_q <= (pos_q == 8'hff) ? pos_q : pos_q + 8'h01;
    end
  end

  // Field capture, steered by the byte position; parameter bytes go to slot plen_q while it is below the buffer size.
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      type_q <= 8'h00;
      id_q <= 8'h00;
      opt_q <= 8'h00;
      a64_q <= 64'h0;
      net_q <= 16'h0;
      cmd_q <= 16'h0;
      par_q <= '0;
      plen_q <= 5'h00;
    end
    else if (take && state_q == RCRF_LEN_LO)
      plen_q <= 5'h00;
    else if (take && state_q == RCRF_BODY)
    begin
      if (pos_q == RCRF_POS_TYPE)
        type_q <= link.data;
      else if (pos_q == RCRF_POS_ID)
        id_q <= link.data;
      else if (pos_q <= RCRF_POS_ADDR64_END)
        a64_q[8*(7-a_idx) +: 8] <= link.data;
      else if (pos_q == RCRF_POS_NET_HI)
        net_q[15:8] <= link.data;
      else if (pos_q == RCRF_POS_NET_LO)
        net_q[7:0] <= link.data;
      else if (pos_q == RCRF_POS_OPT)
        opt_q <= link.data;
      else if (pos_q == RCRF_POS_CMD_HI)
        cmd_q[15:8] <= link.data;
      else if (pos_q == RCRF_POS_CMD_LO)
        cmd_q[7:0] <= link.data;
      else if (plen_q < RCRF_PARAM_MAX_W)
      begin
        // Parameter bytes beyond the buffer are checksummed but not kept.
        par_q[8*plen_q[3:0] +: 8] <= link.data;
        plen_q <= plen_q + 5'h01;
      end
    end
  end

  // Result pulses; a low clock enable stretches them, so a watcher takes their first cycle.
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      req_valid_out <= 1'b0;
      drop_out <= 1'b0;
    end
    else if (ce_in)
    begin
      req_valid_out <= 1'b0;
      drop_out <= 1'b0;
      if (take && state_q == RCRF_CSUM)
      begin
        if (frame_bad)
          drop_out <= 1'b1;
        else
          req_valid_out <= 1'b1;
      end
    end
  end

  // Request fields; they hold from the last good frame until the next one.
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      id_out <= 8'h00;
      reply_out <= 1'b0;
      addr64_out <= 64'h0;
      coord_out <= 1'b0;
      net_out <= 16'h0;
      net_unknown_out <= 1'b0;
      no_ack_out <= 1'b0;
      ext_tmo_out <= 1'b0;
      apply_out <= 1'b0;
      cmd_out <= 16'h0;
      write_out <= 1'b0;
      plen_out <= 5'h00;
      param_out <= '0;
    end
    else if (take && state_q == RCRF_CSUM && !frame_bad)
    begin
      id_out <= id_q;
      reply_out <= (id_q != 8'h00);
      addr64_out <= a64_q;
      coord_out <= (a64_q == 64'h0);
      net_out <= net_q;
      net_unknown_out <= (net_q == RCRF_NET_UNKNOWN);
      no_ack_out <= |(opt_q & RCRF_OPT_NO_ACK);
      ext_tmo_out <= |(opt_q & RCRF_OPT_EXT_TMO);
      apply_out <= |(opt_q & RCRF_OPT_APPLY);
      cmd_out <= cmd_q;
      write_out <= (plen_q != 5'h00);
      plen_out <= plen_q;
      param_out <= par_q;
    end
  end
endmodule

// ===== dv/rcrf_monitor.sv
// Checker for the byte link between the two ends and for the decoded request.
`timescale 1ns/100ps
module rcrf_monitor
(
  input wire logic mclk_in, // clock
  input wire logic rst_in, // reset
  input wire logic [7:0] data, // link byte
  input wire logic valid, // byte offered
  input wire logic ready, // byte taken
  input wire logic req_valid_out, // request pulse
  input wire logic drop_out, // drop pulse
  input wire logic [7:0] id_out, // identifier
  input wire logic reply_out, // reply wanted
  input wire logic no_ack_out, // no acknowledge
  input wire logic ext_tmo_out, // long timeout
  input wire logic apply_out, // apply changes
  input wire logic write_out, // write request
  input wire logic [4:0] plen_out // parameter count
);
  import rcrf_pkg::*;
  logic [15:0] pos_q;
  logic [15:0] len_q;
  logic [7:0] sum_q;
  logic [7:0] opt_q;
  logic [7:0] id_q;
  logic acc;
  logic last;
  assign acc = valid & ready;
  // The length is only trusted from byte three on, so a stale one never ends a frame.
  assign last = acc && pos_q >= 16'h0003 && pos_q == len_q + 16'h0003;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  always_ff @(posedge mclk_in)
  begin
    if (rst_in || last)
      pos_q <= 16'h0000;
    else if (acc)
      pos_q <= pos_q + 16'h0001;
  end
  always_ff @(posedge mclk_in)
  begin
    if (acc && pos_q == 16'h0001)
      len_q <= {data, 8'h00};
    else if (acc && pos_q == 16'h0002)
      len_q <= {len_q[15:8], data};
  end
  always_ff @(posedge mclk_in)
  begin
    if (acc && pos_q == 16'h0002)
      sum_q <= 8'h00;
    else if (acc)
      sum_q <= sum_q + data;
  end
  always_ff @(posedge mclk_in)
  begin
    if (acc && pos_q == 16'h0004)
      id_q <= data;
    if (acc && pos_q == 16'h000f)
      opt_q <= data;
  end
  AST_DELIM: assert property (acc && pos_q == 16'h0000 |-> data == RCRF_DELIM)
    else $error("frame does not open with the delimiter");
  AST_TYPE: assert property (acc && pos_q == 16'h0003 |-> data == RCRF_TYPE_REMOTE_CMD)
    else $error("wrong type code");
  AST_CSUM: assert property (last |-> data == RCRF_CSUM_BASE - sum_q)
    else $error("bad checksum byte");
  AST_HOLD: assert property (valid && !ready |=> valid && $stable(data))
    else $error("offered byte changed before it was taken");
  AST_ANSWER: assert property (last |=> req_valid_out && !drop_out)
    else $error("good frame not reported");
  AST_REPLY: assert property (req_valid_out |-> id_out == id_q
    && reply_out == (id_q != 8'h00))
    else $error("identifier or reply flag wrong");
  AST_OPTS: assert property (req_valid_out |-> no_ack_out == opt_q[0]
    && apply_out == opt_q[1] && ext_tmo_out == opt_q[6])
    else $error("option flags wrong");
  AST_WRITE: assert property (req_valid_out |-> write_out == (len_q > RCRF_HDR_LEN)
    && plen_out == ((len_q > 16'h001f) ? 5'h10 : 5'(len_q - RCRF_HDR_LEN)))
    else $error("write flag or parameter count wrong");
  cover property (last ##1 req_valid_out);
  cover property (acc && pos_q == 16'h000f && data[1]);
  cover property (valid && !ready);
endmodule

// ===== dv/rcrf_tb.sv
// Bench: host end feeds module end; a second module end takes broken frames.
`timescale 1ns/100ps
module rcrf_tb;
  import rcrf_pkg::*;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic ce_in = 1'b1;
  logic jitter = 1'b0;
  logic req_in = 1'b0;
  logic [7:0] id_in = 8'h00;
  logic [63:0] addr64_in = 64'h0;
  logic [15:0] net_in = 16'h0000;
  logic net_known_in = 1'b0;
  logic [7:0] opt_in = 8'h00;
  logic [15:0] cmd_in = 16'h0000;
  logic [4:0] plen_in = 5'h00;
  logic [127:0] param_in = 128'h0;
  logic busy_out, req_valid_out, reply_out, coord_out, net_unknown_out, no_ack_out;
  logic ext_tmo_out, apply_out, write_out, drop_out, rv2, drop2, rv_q, dr_q, dr2_q;
  logic [7:0] id_out;
  logic [63:0] addr64_out;
  logic [15:0] net_out, cmd_out;
  logic [4:0] plen_out;
  logic [127:0] param_out;
  logic [7:0] f[$];
  logic [7:0] exp_b[$];
  logic [243:0] exp_f[$];
  logic [7:0] opts[4] = '{RCRF_OPT_NO_ACK, RCRF_OPT_EXT_TMO, RCRF_OPT_APPLY, 8'h43};
  int mismatches = 0;
  int check_count = 0;
  int drops = 0;
  rcrf_link_if link();
  rcrf_link_if link2();
  rcrf_host u_rcrf_host (.mclk_in, .rst_in, .ce_in, .link, .req_in, .id_in, .addr64_in,
    .net_in, .net_known_in, .opt_in, .cmd_in, .plen_in, .param_in, .busy_out);
  rcrf_module u_rcrf_module (.mclk_in, .rst_in, .ce_in, .link, .req_valid_out, .id_out,
    .reply_out, .addr64_out, .coord_out, .net_out, .net_unknown_out, .no_ack_out,
    .ext_tmo_out, .apply_out, .cmd_out, .write_out, .plen_out, .param_out, .drop_out);
  rcrf_module u_rcrf_module_bad (.mclk_in, .rst_in, .ce_in, .link(link2), .req_valid_out(rv2),
    .id_out(), .reply_out(), .addr64_out(), .coord_out(), .net_out(), .net_unknown_out(),
    .no_ack_out(), .ext_tmo_out(), .apply_out(), .cmd_out(), .write_out(), .plen_out(),
    .param_out(), .drop_out(drop2));
  rcrf_monitor u_rcrf_monitor (.mclk_in, .rst_in, .data(link.data), .valid(link.valid),
    .ready(link.ready), .req_valid_out, .drop_out, .id_out, .reply_out, .no_ack_out,
    .ext_tmo_out, .apply_out, .write_out, .plen_out);
  function automatic logic [127:0] pmask(logic [4:0] p);
    return p[4] ? '1 : (128'h1 << {p[3:0], 3'b000}) - 128'h1;
  endfunction
  task automatic check(string what, logic [243:0] exp, logic [243:0] got);
    check_count++;
    if (exp !== got)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test();
    check("queues left", 244'h0, 244'(exp_b.size() + exp_f.size()));
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic wait_busy(logic lvl);
    for (int i = 0; busy_out !== lvl; i++)
    begin
      if (i > 600)
      begin
        mismatches++;
        end_of_test();
      end
      @(posedge mclk_in);
      #1;
    end
  endtask
  // Builds the expected bytes in f and notes the fields the module must report.
  task automatic build();
    logic [4:0] pl;
    logic [15:0] nn;
    logic [7:0] s;
    pl = plen_in > RCRF_PARAM_MAX_W ? RCRF_PARAM_MAX_W : plen_in;
    nn = net_known_in ? net_in : RCRF_NET_UNKNOWN;
    f = {RCRF_DELIM, 8'h00, 8'(RCRF_HDR_LEN) + {3'b000, pl}, RCRF_TYPE_REMOTE_CMD, id_in};
    for (int i = 7; i >= 0; i--) f.push_back(addr64_in[8*i +: 8]);
    f = {f, nn[15:8], nn[7:0], opt_in, cmd_in[15:8], cmd_in[7:0]};
    for (int i = 0; i < pl; i++) f.push_back(param_in[8*i +: 8]);
    s = 8'h00;
    for (int i = 3; i < f.size(); i++) s += f[i];
    f.push_back(RCRF_CSUM_BASE - s);
    exp_f.push_back({id_in, id_in != 8'h00, addr64_in, addr64_in == 64'h0, nn,
      nn == RCRF_NET_UNKNOWN, opt_in[0], opt_in[6], opt_in[1], cmd_in, pl != 5'h00, pl,
      param_in & pmask(pl)});
  endtask
  // With dup set, start stays raised while busy; the host must not start a second frame.
  task automatic send(logic dup);
    build();
    exp_b = {exp_b, f};
    req_in = 1'b1;
    wait_busy(1'b1);
    req_in = dup;
    wait_busy(1'b0);
    req_in = 1'b0;
    @(posedge mclk_in);
    #1;
  endtask
  task automatic drive2();
    foreach (f[i])
    begin
      link2.data = f[i];
      link2.valid = 1'b1;
      @(posedge mclk_in);
      #1;
    end
    link2.valid = 1'b0;
    link2.data = ~link2.data;
    repeat (4) @(posedge mclk_in);
    #1;
  endtask
  initial forever #4 mclk_in = ~mclk_in;
  always @(posedge mclk_in) #1 ce_in = jitter ? 1'($urandom % 4 != 0) : 1'b1;
  // Pulses are taken on their first cycle, in case a stalled clock enable stretches them.
  always @(posedge mclk_in)
  begin
    rv_q <= req_valid_out;
    dr_q <= drop_out;
    dr2_q <= drop2;
    if (link.valid && link.ready)
      check("byte", 244'(exp_b.pop_front()), 244'(link.data));
    if (req_valid_out && !rv_q) check("fields", exp_f.pop_front(), {id_out, reply_out,
      addr64_out, coord_out, net_out, net_unknown_out, no_ack_out, ext_tmo_out, apply_out,
      cmd_out, write_out, plen_out, param_out & pmask(plen_out)});
    if ((drop_out && !dr_q) || rv2) check("drop", 244'h0, 244'h1);
    if (drop2 && !dr2_q) drops++;
  end
  initial
  begin
    link2.data = 8'h00;
    link2.valid = 1'b0;
    void'($urandom(23627));
    repeat (16) @(posedge mclk_in);
    #1;
    rst_in = 1'b0;
    send(1'b0);
    $display("test query done");
    id_in = 8'h01;
    addr64_in = 64'h0013a20040401122;
    opt_in = RCRF_OPT_APPLY;
    cmd_in = 16'h4248;
    plen_in = 5'h01;
    param_in = 128'h01;
    send(1'b1);
    $display("test apply write done");
    jitter = 1'b1;
    for (int i = 0; i < 16; i++)
    begin
      id_in = 8'($urandom);
      addr64_in = {$urandom, $urandom};
      {net_known_in, net_in} = 17'($urandom);
      opt_in = opts[i % 4];
      cmd_in = 16'($urandom);
      plen_in = i < 2 ? 5'h10 : 5'($urandom % 21);
      param_in = {$urandom, $urandom, $urandom, $urandom};
      send(1'b0);
    end
    $display("test random done");
    jitter = 1'b0;
    repeat (4) @(posedge mclk_in);
    #1;
    build();
    void'(exp_f.pop_back());
    f[$] = f[$] ^ 8'h01;
    drive2();
    f[3] = 8'h08;
    f[$] = (f[$] ^ 8'h01) + 8'h0f;
    drive2();
    f = {RCRF_DELIM, 8'h00, 8'h00, RCRF_CSUM_BASE};
    drive2();
    check("drops", 244'h3, 244'(drops));
    $display("test broken frames done");
    end_of_test();
  end
endmodule
